// ==== pwr_mode_defines.svh ====
`ifndef PWR_MODE_DEFINES_SVH
`define PWR_MODE_DEFINES_SVH

// ----------------------------------------
// Field positions and timing
// ----------------------------------------
`define SLEEP_VARIANT_BIT 5
`define FAST_IRQ_COUNT 8
`define WAKE_PULSE_NS 40
`define CLK_PERIOD_NS 20
// Least pulse rounds up to whole cycles
`define WAKE_PULSE_CYC ((`WAKE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MODE_RESET 2'h0

`endif

// ==== pwr_mode_pkg.sv ====
package pwr_mode_pkg;

    typedef enum logic [2:0]
    {
        ST_RUN = 3'b000,
        ST_IDLE_WAIT = 3'b001,
        ST_IDLE = 3'b010,
        ST_PD_WAIT = 3'b011,
        ST_PD_PROT = 3'b100,
        ST_PD_INTR = 3'b101
    } pwr_state_t;

    // Instruction requests from the CPU
    typedef struct packed
    {
        logic idle_instruction;
        logic deep_sleep_instruction;
    } cpu_req_t;

    // Bus status relevant to entry
    typedef struct packed
    {
        logic bus_busy;
        logic ready_enabled;
        logic ready_seen;
    } bus_stat_t;

    // Wake sources besides fast pins
    typedef struct packed
    {
        logic any_irq;
        logic rtc_irq;
        logic can_irq;
        logic i2c_irq;
    } wake_src_t;

    // Gating outputs
    typedef struct packed
    {
        logic cpu_halt;
        logic periph_halt;
        logic wdt_halt;
        logic main_osc_stop;
        logic rtc_run;
    } gate_t;

endpackage

// ==== wake_sync.sv ====
`timescale 1ns/1ps
`include "pwr_mode_defines.svh"

// Two-stage synchroniser for the fast wake pins, level in and level out
module wake_sync
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Raw and synchronised
    input wire logic [`FAST_IRQ_COUNT-1:0] async_in,
    output logic [`FAST_IRQ_COUNT-1:0] sync_out
);

    logic [`FAST_IRQ_COUNT-1:0] meta_q;

    // No reset on purpose: both stages follow the pin while reset is held,
    // so an active-low pin leaves reset at its idle level, not as a request.
    // Limitation: reset must be held for at least two clock edges.
    always_ff @(posedge ref_clk)
    begin
        meta_q <= async_in;
        sync_out <= meta_q;
    end

endmodule

// ==== pwr_mode_ctrl.sv ====
`timescale 1ns/1ps
`include "pwr_mode_defines.svh"

// Function
// R01: Idle halts CPU, peripherals keep running
// R02: Power-down halts CPU, peripherals, watchdog
// R03: Modes entered only by their instructions
// R04: Finish pending bus transaction before entry
// R05: Refuse entry when ready enabled, unseen
// R06: Any interrupt ends idle
// R07: Low-power oscillator running stops main oscillator
// R08: Detect low-power oscillator, keep as reference
// R09: Main-only reference keeps main oscillator running
// R10: Software sets regulator-off before power-down
// R11: Variant bit clear selects protected power-down
// R12: Protected entry needs NMI low
// R13: Protected exit only by reset pin
// R14: Variant bit set selects interruptible power-down
// R15: Interruptible entry needs enabled pins inactive
// R16: Interruptible exit on reset, pins, RTC, CAN, I2C
// R17: Wake pin held at least 40 ns
// R18: Clearing RAM enable freezes interface immediately
// R19: RAM stays frozen until enable set again
// R20: Enable set blocks standby switch on dips
// R21: Reset release returns RAM to main rail
// R22: Reset pin held low through power ramps
// R23: Standby RTC counts only on low-power oscillator
// R24: Reset returns run; wake events synchronised (code synchronises only the fast wake pins, through wake_sync)
module pwr_mode_ctrl
    import pwr_mode_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // CPU side
    input wire cpu_req_t cpu_req,
    input wire bus_stat_t bus_stat,
    input wire logic nmi_n,
    input wire logic [7:0] system_config_reg,
    input wire logic main_regulator_off,
    // Wake sources
    input wire logic [`FAST_IRQ_COUNT-1:0] fast_ext_irq_pin,
    input wire logic [`FAST_IRQ_COUNT-1:0] fast_irq_enable,
    input wire logic [`FAST_IRQ_COUNT-1:0] fast_irq_active_high,
    input wire wake_src_t wake_src,
    input wire logic reset_input_pin_n,
    // Oscillator and stand-by RAM
    input wire logic lowpower_osc_detected,
    input wire logic lowpower_ref_disable,
    input wire logic rtc_enable,
    input wire logic standby_ram_enable,
    input wire logic core_supply_low,
    // Outputs
    output gate_t gate,
    output pwr_state_t state,
    output logic entry_refused,
    output logic resume_pulse,
    output logic rtc_ref_lowpower,
    output logic ram_frozen,
    output logic ram_on_standby_rail
);

    // ----------------------------------------
    // Wake pin conditioning
    // ----------------------------------------
    logic [`FAST_IRQ_COUNT-1:0] pin_sync;
    logic [`FAST_IRQ_COUNT-1:0] pin_active;
    logic [`FAST_IRQ_COUNT-1:0] pin_wake;
    logic [`FAST_IRQ_COUNT-1:0] pin_prev_q;

    wake_sync u_wake_sync
    (
        .ref_clk(ref_clk),
        .rst(rst),
        .async_in(fast_ext_irq_pin),
        .sync_out(pin_sync)
    );

    // Polarity and enable per pin; a pin needs two samples in a row
    genvar gi;
    generate
        for (gi = 0; gi < `FAST_IRQ_COUNT; gi++)
        begin : g_pin
            assign pin_active[gi] = fast_irq_enable[gi] &
                (pin_sync[gi] ~^ fast_irq_active_high[gi]);
            assign pin_wake[gi] = pin_active[gi] & pin_prev_q[gi]; // R17
        end
    endgenerate

    // Previous sample for the width filter; WAKE_PULSE_CYC is two cycles
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            pin_prev_q <= '0;
        else
            pin_prev_q <= pin_active;
    end

    logic any_pin_wake;
    logic any_pin_active_raw;
    assign any_pin_wake = |pin_wake;
    // Entry check looks at live enabled pin levels through the synchroniser
    assign any_pin_active_raw = |pin_active; // R15

    // ----------------------------------------
    // Entry qualification
    // ----------------------------------------
    logic variant_intr;
    logic ready_bad;
    logic pd_ok;
    assign variant_intr = system_config_reg[`SLEEP_VARIANT_BIT]; // R11 R14
    assign ready_bad = bus_stat.ready_enabled & ~bus_stat.ready_seen; // R05
    // Protected needs NMI low, interruptible needs quiet pins
    assign pd_ok = variant_intr ? ~any_pin_active_raw : ~nmi_n; // R12 R15

    logic reset_pin_wake;
    assign reset_pin_wake = ~reset_input_pin_n;

    // ----------------------------------------
    // Mode state machine
    // ----------------------------------------
    pwr_state_t state_q;
    pwr_state_t state_d;
    logic refuse_d;
    logic resume_d;

    always_comb
    begin
        state_d = state_q;
        refuse_d = 1'b0;
        resume_d = 1'b0;
        case (state_q)
            ST_RUN:
            begin
                if (cpu_req.idle_instruction) // R03
                    state_d = ST_IDLE_WAIT;
                else if (cpu_req.deep_sleep_instruction) // R03
                    state_d = ST_PD_WAIT;
            end
            ST_IDLE_WAIT:
            begin
                // Let the bus cycle drain before halting
                if (!bus_stat.bus_busy) // R04
                begin
                    if (ready_bad) // R05
                    begin
                        refuse_d = 1'b1;
                        state_d = ST_RUN;
                    end
                    else
                        state_d = ST_IDLE;
                end
            end
            ST_IDLE:
            begin
                if (wake_src.any_irq | any_pin_wake) // R06
                begin
                    resume_d = 1'b1;
                    state_d = ST_RUN;
                end
            end
            ST_PD_WAIT:
            begin
                if (!bus_stat.bus_busy) // R04
                begin
                    if (ready_bad || !pd_ok) // R05 R12 R15
                    begin
                        refuse_d = 1'b1;
                        state_d = ST_RUN;
                    end
                    else if (variant_intr)
                        state_d = ST_PD_INTR; // R14
                    else
                        state_d = ST_PD_PROT; // R11
                end
            end
            ST_PD_PROT:
            begin
                // Interrupts ignored; reset pin reaches us through rst
                state_d = ST_PD_PROT; // R13
            end
            ST_PD_INTR:
            begin
                if (reset_pin_wake | any_pin_wake | wake_src.rtc_irq |
                    wake_src.can_irq | wake_src.i2c_irq) // R16
                begin
                    resume_d = 1'b1;
                    state_d = ST_RUN;
                end
            end
            default:
                state_d = ST_RUN;
        endcase
    end

    // State register; reset always lands in run
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            state_q <= ST_RUN; // R24
        else
            state_q <= state_d;
    end

    // Status pulses
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            entry_refused <= 1'b0;
            resume_pulse <= 1'b0;
        end
        else
        begin
            entry_refused <= refuse_d;
            resume_pulse <= resume_d;
        end
    end

    assign state = state_q;

    // ----------------------------------------
    // Oscillator reference selection
    // ----------------------------------------
    logic lp_ref_q;

    // Sticky once seen, only reset or software disable drops it
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            lp_ref_q <= 1'b0;
        else if (lowpower_ref_disable)
            lp_ref_q <= 1'b0;
        else if (lowpower_osc_detected)
            lp_ref_q <= 1'b1; // R08
    end

    assign rtc_ref_lowpower = lp_ref_q;

    // ----------------------------------------
    // Clock gating outputs
    // ----------------------------------------
    logic in_pd;
    logic in_idle;
    assign in_pd = (state_q == ST_PD_PROT) || (state_q == ST_PD_INTR);
    assign in_idle = (state_q == ST_IDLE);

    // Registered so gates never glitch
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            gate <= gate_t'({4'h0, rtc_enable & standby_rail_q & lowpower_osc_detected}); // R23
        else
        begin
            gate.cpu_halt <= (state_d == ST_IDLE) || (state_d == ST_PD_PROT) ||
                (state_d == ST_PD_INTR); // R01 R02
            gate.periph_halt <= (state_d == ST_PD_PROT) || (state_d == ST_PD_INTR); // R02
            gate.wdt_halt <= (state_d == ST_PD_PROT) || (state_d == ST_PD_INTR); // R02
            // Main osc stops in power-down unless it is the only RTC reference
            gate.main_osc_stop <= ((state_d == ST_PD_PROT) || (state_d == ST_PD_INTR)) &&
                (lp_ref_q || !rtc_enable); // R07 R09
            gate.rtc_run <= rtc_enable; // R07 R09
        end
    end

    // ----------------------------------------
    // Stand-by RAM control
    // ----------------------------------------
    logic frozen_q;
    logic standby_rail_q;
    logic rst_prev_q;

    // Freeze follows enable low at once; only a set unfreezes
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            frozen_q <= frozen_q | ~standby_ram_enable; // R19
        else if (!standby_ram_enable)
            frozen_q <= 1'b1; // R18
        else
            frozen_q <= 1'b0; // R19
    end

    // Reset edge tracking for rail return
    always_ff @(posedge ref_clk)
    begin
        rst_prev_q <= rst;
    end

    // Rail moves to stand-by on reset while frozen; supply dips ignored if enabled
    always_ff @(posedge ref_clk)
    begin
        if (rst && frozen_q && core_supply_low)
            standby_rail_q <= 1'b1; // R18 R20
        else if (rst && frozen_q)
            standby_rail_q <= 1'b1; // R18
        else if (rst_prev_q && !rst)
            standby_rail_q <= 1'b0; // R21
        else if (!rst && !frozen_q)
            standby_rail_q <= 1'b0; // R20
    end

    // Immediate freeze path: combinational so no access slips through
    assign ram_frozen = frozen_q | ~standby_ram_enable; // R18
    assign ram_on_standby_rail = standby_rail_q; // R18 R21

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence pd_request_s;
        state_q == ST_PD_WAIT && !bus_stat.bus_busy;
    endsequence

    sequence pd_enter_s;
        ##1 in_pd;
    endsequence

    idle_cpu_halt_a: assert property (@(posedge ref_clk) disable iff (rst)
        in_idle |-> gate.cpu_halt && !gate.periph_halt) // R01
        else $error("idle gating wrong");

    pd_all_halt_a: assert property (@(posedge ref_clk) disable iff (rst)
        in_pd |-> gate.cpu_halt && gate.periph_halt && gate.wdt_halt) // R02
        else $error("power-down gating wrong");

    only_by_instr_a: assert property (@(posedge ref_clk) disable iff (rst)
        state_q == ST_RUN && !cpu_req.idle_instruction &&
        !cpu_req.deep_sleep_instruction |=> state_q == ST_RUN) // R03
        else $error("mode left run without instruction");

    bus_drain_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == ST_PD_WAIT || state_q == ST_IDLE_WAIT) && bus_stat.bus_busy
        |=> state_q == $past(state_q)) // R04
        else $error("entry before bus drained");

    ready_refuse_a: assert property (@(posedge ref_clk) disable iff (rst)
        pd_request_s and ready_bad |=> entry_refused && state_q == ST_RUN) // R05
        else $error("ready refusal missed");

    idle_wake_a: assert property (@(posedge ref_clk) disable iff (rst)
        in_idle && wake_src.any_irq |=> state_q == ST_RUN ##0 resume_pulse) // R06
        else $error("idle did not end");

    prot_entry_a: assert property (@(posedge ref_clk) disable iff (rst)
        pd_request_s and (!ready_bad && !variant_intr && !nmi_n)
        |-> pd_enter_s ##0 state_q == ST_PD_PROT) // R11 R12
        else $error("protected entry wrong");

    prot_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        state_q == ST_PD_PROT |=> state_q == ST_PD_PROT [*2]) // R13
        else $error("protected power-down left early");

    intr_wake_a: assert property (@(posedge ref_clk) disable iff (rst)
        state_q == ST_PD_INTR && wake_src.rtc_irq |=> state_q == ST_RUN) // R16
        else $error("interruptible wake missed");

    osc_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
        in_pd && $past(rtc_enable) && !$past(lp_ref_q) |-> !gate.main_osc_stop) // R09
        else $error("main oscillator stopped wrongly");

    ref_sticky_a: assert property (@(posedge ref_clk) disable iff (rst)
        lp_ref_q && !lowpower_ref_disable |=> lp_ref_q) // R08
        else $error("low-power reference dropped");

    ram_freeze_a: assert property (@(posedge ref_clk) disable iff (rst)
        !standby_ram_enable |-> ram_frozen ##1 ram_frozen) // R18
        else $error("ram not frozen");

endmodule

// ==== wake_pin_model.sv ====
`timescale 1ns/1ps
`include "pwr_mode_defines.svh"

// ----------------------------------------
// Fast wake pin source
// ----------------------------------------
// Pins rest at their inactive level; the bench decides how long a request
// stands, so pulses shorter than the wake minimum can probe the filter.
module wake_pin_model
(
    // Active level per pin
    input wire logic [`FAST_IRQ_COUNT-1:0] act_high,
    // Pins toward the block
    output logic [`FAST_IRQ_COUNT-1:0] pins
);
    logic [`FAST_IRQ_COUNT-1:0] on_q = '0;

    // Active level only where a request stands
    assign pins = ~(act_high ^ on_q);

    // Called by the bench just after a falling edge
    task automatic drive_pin(input int idx, input logic on);
        on_q[idx] = on;
    endtask
endmodule

// ==== power_reduction_mode_control_tb.sv ====
`timescale 1ns/1ps
`include "pwr_mode_defines.svh"

// ----------------------------------------
// Mode controller bench
// ----------------------------------------
module power_reduction_mode_control_tb import pwr_mode_pkg::*;;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic rst_pin_n = 1'b0;
    cpu_req_t cpu_req = '0;
    bus_stat_t bus_stat = '0;
    logic nmi_n = 1'b1;
    logic [7:0] cfg = 8'h00;
    logic reg_off = 1'b0;
    logic [7:0] pins;
    logic [7:0] irq_en = 8'hff;
    logic [7:0] act_hi = 8'h0f;
    wake_src_t wsrc = '0;
    logic lp_det = 1'b0;
    logic lp_dis = 1'b0;
    logic rtc_en = 1'b1;
    logic ram_en = 1'b1;
    logic sup_low = 1'b0;
    gate_t gate;
    pwr_state_t state;
    logic refused;
    logic resume;
    logic rtc_lp;
    logic frozen;
    logic sb_rail;
    int error_cnt = 0;
    int n_checks = 0;

    // Free-running 50 MHz clock
    always #10 ref_clk = ~ref_clk;

    wake_pin_model wk (.act_high(act_hi), .pins(pins));

    pwr_mode_ctrl dut
    (
        .ref_clk(ref_clk), .rst(rst), .cpu_req(cpu_req), .bus_stat(bus_stat),
        .nmi_n(nmi_n), .system_config_reg(cfg), .main_regulator_off(reg_off),
        .fast_ext_irq_pin(pins), .fast_irq_enable(irq_en),
        .fast_irq_active_high(act_hi), .wake_src(wsrc), .reset_input_pin_n(rst_pin_n),
        .lowpower_osc_detected(lp_det), .lowpower_ref_disable(lp_dis),
        .rtc_enable(rtc_en), .standby_ram_enable(ram_en), .core_supply_low(sup_low),
        .gate(gate), .state(state), .entry_refused(refused), .resume_pulse(resume),
        .rtc_ref_lowpower(rtc_lp), .ram_frozen(frozen), .ram_on_standby_rail(sb_rail)
    );

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        if (error_cnt == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // Reset pin and system reset move together, as on the board
    task automatic set_rst(input logic on);
        rst = on;
        rst_pin_n = ~on;
    endtask

    // Instruction pulse, then the mode or the one-cycle refusal two edges later
    task automatic enter(input logic pd, input pwr_state_t exp, input logic exp_ref);
        cpu_req = {~pd, pd};
        tick(1);
        cpu_req = '0;
        tick(1);
        chk(state, exp);
        chk(refused, exp_ref);
    endtask

    task automatic wait_run(input int n, output logic ok, output logic res);
        ok = 1'b0;
        res = 1'b0;
        repeat (n)
        begin
            tick(1);
            res |= resume;
            if (state === ST_RUN)
                ok = 1'b1;
        end
    endtask

    task automatic s_idle;
        logic ok;
        logic res;
        tick(5);
        chk(state, ST_RUN);
        chk(gate, 5'h01);
        bus_stat.bus_busy = 1'b1;
        cpu_req.idle_instruction = 1'b1;
        tick(1);
        cpu_req = '0;
        tick(4);
        chk(state, ST_IDLE_WAIT);
        bus_stat.bus_busy = 1'b0;
        tick(2);
        chk(state, ST_IDLE);
        chk({gate.cpu_halt, gate.periph_halt}, 2'b10);
        wsrc.any_irq = 1'b1;
        wait_run(8, ok, res);
        wsrc.any_irq = 1'b0;
        chk({ok, res, gate.cpu_halt}, 3'b110);
    endtask

    task automatic s_prot;
        bus_stat = 3'b010;
        nmi_n = 1'b0;
        for (int k = 0; k < 2; k++)
            enter(k[0], ST_RUN, 1'b1);
        bus_stat = '0;
        reg_off = 1'b1;
        nmi_n = 1'b1;
        enter(1'b1, ST_RUN, 1'b1);
        nmi_n = 1'b0;
        enter(1'b1, ST_PD_PROT, 1'b0);
        nmi_n = 1'b1;
        chk(gate[4:1], 4'b1110);
        wsrc = '1;
        wk.drive_pin(0, 1'b1);
        tick(10);
        chk(state, ST_PD_PROT);
        wsrc = '0;
        wk.drive_pin(0, 1'b0);
        set_rst(1'b1);
        tick(2);
        set_rst(1'b0);
        tick(1);
        chk(state, ST_RUN);
        chk(gate, 5'h01);
    endtask

    // Frozen interface must outlive a reset and the rail swap around it
    task automatic s_ram;
        ram_en = 1'b0;
        #1;
        chk(frozen, 1'b1);
        tick(1);
        lp_det = 1'b1;
        set_rst(1'b1);
        tick(2);
        chk(sb_rail, 1'b1);
        chk(gate.rtc_run, 1'b1);
        set_rst(1'b0);
        lp_det = 1'b0;
        tick(1);
        chk({sb_rail, frozen}, 2'b01);
        ram_en = 1'b1;
        tick(1);
        chk(frozen, 1'b0);
        sup_low = 1'b1;
        tick(3);
        chk({frozen, sb_rail}, 2'b00);
        sup_low = 1'b0;
    endtask

    task automatic s_intr;
        logic ok;
        logic res;
        lp_det = 1'b1;
        tick(4);
        lp_det = 1'b0;
        tick(4);
        chk(rtc_lp, 1'b1);
        cfg = 8'h20;
        wk.drive_pin(5, 1'b1);
        tick(4);
        enter(1'b1, ST_RUN, 1'b1);
        irq_en = 8'hdf;
        enter(1'b1, ST_PD_INTR, 1'b0);
        chk(gate[4:1], 4'b1111);
        wk.drive_pin(5, 1'b0);
        wk.drive_pin(2, 1'b1);
        tick(1);
        wk.drive_pin(2, 1'b0);
        tick(8);
        chk(state, ST_PD_INTR);
        irq_en = 8'hff;
        for (int k = 0; k < 4; k++)
        begin
            if (k > 0)
                enter(1'b1, ST_PD_INTR, 1'b0);
            if (k == 0)
                wk.drive_pin(2, 1'b1);
            else
                wsrc = wake_src_t'(4'h8 >> k);
            wait_run(10, ok, res);
            chk({ok, res}, 2'b11);
            wk.drive_pin(2, 1'b0);
            wsrc = '0;
            tick(4);
        end
        lp_dis = 1'b1;
        tick(3);
        chk(rtc_lp, 1'b0);
    endtask

    // Whole run is well under this span
    initial
    begin
        #400000;
        error_cnt++;
        give_verdict();
    end

    initial
    begin
        tick(10);
        set_rst(1'b0);
        s_idle();
        s_prot();
        s_ram();
        s_intr();
        give_verdict();
    end
endmodule
